// ---- rtl/pstc_core.sv ----
// Processor state and privilege controller: processing state, status word,
// stop condition, stack selection and address space code of bus cycles.
// Assumes the sequencer gives one-cycle event pulses synchronous to clock
// and leaves a halted core alone until the reset source acts.
`timescale 1ns/1ns
`default_nettype none
module pstc_core (
    // Clock and reset
    input  wire logic                              clock,
    input  wire logic                              sys_rst,
    // Instruction issue from the sequencer
    input  wire logic                              instr_valid,
    input  wire logic                              instr_privileged,
    input  wire logic                              instr_status_write,
    input  wire logic                              instr_stop,
    input  wire logic [pstc_pkg::PSTC_SW_W-1:0]    instr_status_value,
    output logic                                   instr_accept,
    // Exception sources
    input  wire logic                              exc_interrupt_ack,
    input  wire logic                              exc_trace,
    input  wire logic                              exc_trap,
    input  wire logic                              exc_other,
    input  wire logic                              bus_error,
    input  wire logic                              address_error,
    input  wire logic                              handler_begin,
    // Bus cycle requests
    input  wire logic                              bus_req,
    input  wire logic                              bus_program,
    input  wire logic                              bus_cpu_space,
    output logic                                   bus_start,
    output logic [2:0]                             address_space_code,
    // Processor state
    output pstc_pkg::pstc_state_e                  proc_state,
    output logic                                   stopped,
    output logic                                   supervisor,
    output logic                                   priv_violation,
    output logic [pstc_pkg::PSTC_SW_W-1:0]         status_word,
    output logic [pstc_pkg::PSTC_SW_W-1:0]         saved_status_word,
    output pstc_pkg::pstc_stack_e                  stack_select
);
    import pstc_pkg::*;

    // ************************************************************
    // Processing state and status word
    // ************************************************************

    pstc_state_e          state_q, state_d;
    logic                 stopped_q, stopped_d;
    logic [PSTC_SW_W-1:0] sw_q, sw_d;
    logic [PSTC_SW_W-1:0] saved_q, saved_d;
    logic                 viol_q, viol_d;
    logic                 exc_event;
    logic                 needs_priv;
    logic                 issue;
    logic                 violation;
    logic                 execute;

    always_comb begin
        exc_event  = exc_interrupt_ack | exc_trace | exc_trap | exc_other
                   | bus_error | address_error;
        // Status writes can move the supervisor bit, stop is supervisor-only
        needs_priv = instr_privileged | instr_status_write | instr_stop;
        // A stopped core takes no instruction until an exception wakes it
        issue      = (state_q == PSTC_NORMAL) && !stopped_q && instr_valid && !exc_event;
        // The master bit plays no part in the privilege check
        violation  = issue && needs_priv && !sw_q[PSTC_SW_S_BIT];
        execute    = issue && !violation;
    end

    always_comb begin
        state_d   = state_q;
        stopped_d = stopped_q;
        sw_d      = sw_q;
        saved_d   = saved_q;
        viol_d    = 1'b0;
        case (state_q)
            PSTC_NORMAL: begin
                if (exc_event || violation) begin
                    // Whole word saved first, then privilege raised
                    state_d             = PSTC_EXCEPTION;
                    stopped_d           = 1'b0;
                    saved_d             = sw_q;
                    sw_d[PSTC_SW_S_BIT] = 1'b1;
                    viol_d              = violation;
                    if (exc_interrupt_ack) begin
                        sw_d[PSTC_SW_M_BIT] = 1'b0;
                    end
                end else if (execute) begin
                    if (instr_status_write) begin
                        sw_d = instr_status_value;
                    end
                    if (instr_stop) begin
                        stopped_d = 1'b1;
                    end
                end
            end
            PSTC_EXCEPTION: begin
                if (bus_error || address_error) begin
                    state_d = PSTC_HALTED;
                end else if (handler_begin) begin
                    state_d = PSTC_NORMAL;
                end
            end
            PSTC_HALTED: begin
                state_d = PSTC_HALTED;
            end
            default: begin
                // An illegal encoding is treated as a fatal fault
                state_d = PSTC_HALTED;
            end
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q   <= PSTC_NORMAL;
            stopped_q <= 1'b0;
            sw_q      <= PSTC_SW_RESET;
            saved_q   <= PSTC_SW_RESET;
            viol_q    <= 1'b0;
        end else begin
            state_q   <= state_d;
            stopped_q <= stopped_d;
            sw_q      <= sw_d;
            saved_q   <= saved_d;
            viol_q    <= viol_d;
        end
    end

    // ************************************************************
    // Mode bits and helpers
    // ************************************************************

    pstc_mode_if mode_bus ();

    // Exception processing always counts as supervisor, from its first cycle in the exception state
    assign mode_bus.supervisor   = sw_q[PSTC_SW_S_BIT] | (state_q == PSTC_EXCEPTION);
    assign mode_bus.master       = sw_q[PSTC_SW_M_BIT];
    assign mode_bus.in_exception = (state_q == PSTC_EXCEPTION);
    assign mode_bus.bus_allowed  = (state_q != PSTC_HALTED) && !stopped_q;

    pstc_stack_sel u_stack_sel (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .mode         (mode_bus),
        .stack_select (stack_select)
    );

    pstc_space_enc u_space_enc (
        .clock              (clock),
        .sys_rst            (sys_rst),
        .mode               (mode_bus),
        .bus_req            (bus_req),
        .bus_program        (bus_program),
        .bus_cpu_space      (bus_cpu_space),
        .bus_start          (bus_start),
        .address_space_code (address_space_code)
    );

    assign instr_accept      = execute;
    assign proc_state        = state_q;
    assign stopped           = stopped_q;
    assign supervisor        = mode_bus.supervisor;
    assign priv_violation    = viol_q;
    assign status_word       = sw_q;
    assign saved_status_word = saved_q;

    // ************************************************************
    // Checks
    // ************************************************************

    sequence s_exc_entry;
        state_q == PSTC_NORMAL && (exc_event || violation);
    endsequence

    sequence s_exc_done;
        state_q == PSTC_EXCEPTION && handler_begin && !bus_error && !address_error;
    endsequence

    sequence s_exc_fault;
        state_q == PSTC_EXCEPTION && (bus_error || address_error);
    endsequence

    property p_one_state;
        @(posedge clock) disable iff (sys_rst)
        state_q inside {PSTC_NORMAL, PSTC_EXCEPTION, PSTC_HALTED};
    endproperty
    a_one_state: assert property (p_one_state) else $error("illegal state");

    property p_enter_exc;
        @(posedge clock) disable iff (sys_rst)
        s_exc_entry |=> state_q == PSTC_EXCEPTION && !stopped_q;
    endproperty
    a_enter_exc: assert property (p_enter_exc) else $error("exception not entered");

    property p_handler_done;
        @(posedge clock) disable iff (sys_rst)
        s_exc_entry ##1 (state_q == PSTC_EXCEPTION && !handler_begin
            && !bus_error && !address_error) |=> state_q == PSTC_EXCEPTION;
    endproperty
    a_handler_done: assert property (p_handler_done) else $error("left exception early");

    property p_handler_exit;
        @(posedge clock) disable iff (sys_rst)
        s_exc_done |=> state_q == PSTC_NORMAL;
    endproperty
    a_handler_exit: assert property (p_handler_exit) else $error("handler start missed");

    property p_halt_on_fault;
        @(posedge clock) disable iff (sys_rst)
        s_exc_fault |=> state_q == PSTC_HALTED ##1 (state_q == PSTC_HALTED && !bus_start);
    endproperty
    a_halt_on_fault: assert property (p_halt_on_fault) else $error("double fault not halted");

    property p_halt_holds;
        @(posedge clock) disable iff (sys_rst)
        state_q == PSTC_HALTED |=> state_q == PSTC_HALTED && !bus_start;
    endproperty
    a_halt_holds: assert property (p_halt_holds) else $error("halt left without reset");

    property p_stop_quiet;
        @(posedge clock) disable iff (sys_rst)
        stopped_q |-> state_q == PSTC_NORMAL ##1 !bus_start;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stopped core ran a cycle");

    property p_super_runs;
        @(posedge clock) disable iff (sys_rst)
        issue && sw_q[PSTC_SW_S_BIT] |-> instr_accept && !violation;
    endproperty
    a_super_runs: assert property (p_super_runs) else $error("supervisor refused");

    property p_user_refused;
        @(posedge clock) disable iff (sys_rst)
        issue && needs_priv && !sw_q[PSTC_SW_S_BIT]
            |-> !instr_accept ##1 (priv_violation && sw_q == {$past(sw_q[15:14]), 1'b1,
                $past(sw_q[12:0])});
    endproperty
    a_user_refused: assert property (p_user_refused) else $error("user ran privileged");

    property p_reset_interrupt_mode;
        @(posedge clock) disable iff (sys_rst)
        $past(sys_rst) |-> !sw_q[PSTC_SW_M_BIT] && stack_select != PSTC_SP_MASTER;
    endproperty
    a_reset_interrupt_mode: assert property (p_reset_interrupt_mode) else $error("reset master");

    property p_master_sources;
        @(posedge clock) disable iff (sys_rst)
        $changed(sw_q[PSTC_SW_M_BIT]) |-> $past(execute && instr_status_write)
            || $past(state_q == PSTC_NORMAL && exc_interrupt_ack);
    endproperty
    a_master_sources: assert property (p_master_sources) else $error("master bit moved");

    property p_irq_saves_master;
        @(posedge clock) disable iff (sys_rst)
        state_q == PSTC_NORMAL && exc_interrupt_ack
            |=> !sw_q[PSTC_SW_M_BIT] && saved_q == $past(sw_q)
            && stack_select == PSTC_SP_INTERRUPT;
    endproperty
    a_irq_saves_master: assert property (p_irq_saves_master) else $error("master not saved");

    property p_entry_super;
        @(posedge clock) disable iff (sys_rst)
        s_exc_entry |=> sw_q[PSTC_SW_S_BIT] && saved_q == $past(sw_q) && supervisor;
    endproperty
    a_entry_super: assert property (p_entry_super) else $error("entry not supervisor");

    property p_viol_pulse;
        @(posedge clock) disable iff (sys_rst)
        priv_violation |=> !priv_violation;
    endproperty
    a_viol_pulse: assert property (p_viol_pulse) else $error("violation stuck");

    property p_status_load;
        @(posedge clock) disable iff (sys_rst)
        execute && instr_status_write |=> sw_q == $past(instr_status_value);
    endproperty
    a_status_load: assert property (p_status_load) else $error("status not loaded");

    property p_halt_refuse;
        @(posedge clock) disable iff (sys_rst)
        state_q == PSTC_HALTED |-> !instr_accept;
    endproperty
    a_halt_refuse: assert property (p_halt_refuse) else $error("halted took work");
endmodule
`default_nettype wire

// ---- rtl/pstc_pkg.sv ----
// Shared types and constants of the processor state and privilege controller.
// Assumes a single 100 MHz core clock and an asynchronous active-high reset.
package pstc_pkg;
    // Processing states
    typedef enum logic [1:0] {
        PSTC_NORMAL,
        PSTC_EXCEPTION,
        PSTC_HALTED
    } pstc_state_e;

    // Stack pointer in use for stack operations
    typedef enum logic [1:0] {
        PSTC_SP_USER,
        PSTC_SP_INTERRUPT,
        PSTC_SP_MASTER
    } pstc_stack_e;

    // Status word layout and value after reset
    localparam int          PSTC_SW_W     = 16;
    localparam int          PSTC_SW_S_BIT = 13;
    localparam int          PSTC_SW_M_BIT = 12;
    localparam logic [15:0] PSTC_SW_RESET = 16'h2000;

    // Address space codes
    localparam logic [2:0] PSTC_ASC_USER_DATA = 3'h1;
    localparam logic [2:0] PSTC_ASC_USER_PROG = 3'h2;
    localparam logic [2:0] PSTC_ASC_SUP_DATA  = 3'h5;
    localparam logic [2:0] PSTC_ASC_SUP_PROG  = 3'h6;
    localparam logic [2:0] PSTC_ASC_CPU       = 3'h7;
    localparam logic [2:0] PSTC_ASC_RESET     = 3'h0;
endpackage

// ---- rtl/pstc_mode_if.sv ----
// Mode bits passed from the state controller to its helper modules.
// Assumes one producer (ctrl) and any number of readers (sink).
`timescale 1ns/1ns
`default_nettype none
interface pstc_mode_if;
    logic supervisor;
    logic master;
    logic in_exception;
    logic bus_allowed;

    modport ctrl (output supervisor, output master, output in_exception, output bus_allowed);
    modport sink (input supervisor, input master, input in_exception, input bus_allowed);
endinterface
`default_nettype wire

// ---- rtl/pstc_stack_sel.sv ----
// Stack pointer selection from the privilege and stack mode bits.
// Assumes the mode bits come straight from registers in the controller.
`timescale 1ns/1ns
`default_nettype none
module pstc_stack_sel (
    // Clock and reset, used by checks only
    input  wire logic                  clock,
    input  wire logic                  sys_rst,
    // Mode bits
    pstc_mode_if.sink                  mode,
    // Selected stack
    output pstc_pkg::pstc_stack_e      stack_select
);
    import pstc_pkg::*;

    always_comb begin
        if (!mode.supervisor) begin
            stack_select = PSTC_SP_USER;
        end else if (mode.master) begin
            stack_select = PSTC_SP_MASTER;
        end else begin
            stack_select = PSTC_SP_INTERRUPT;
        end
    end

    property p_stack_pick;
        @(posedge clock) disable iff (sys_rst)
        stack_select == (!mode.supervisor ? PSTC_SP_USER :
                         mode.master ? PSTC_SP_MASTER : PSTC_SP_INTERRUPT);
    endproperty
    a_stack_pick: assert property (p_stack_pick) else $error("wrong stack pointer");
endmodule
`default_nettype wire

// ---- rtl/pstc_space_enc.sv ----
// Bus cycle launch and address space code, registered one cycle after request.
// Assumes the sequencer holds no request while the controller forbids bus cycles.
`timescale 1ns/1ns
`default_nettype none
module pstc_space_enc (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Mode bits
    pstc_mode_if.sink       mode,
    // Bus cycle request
    input  wire logic       bus_req,
    input  wire logic       bus_program,
    input  wire logic       bus_cpu_space,
    // Bus cycle launch
    output logic            bus_start,
    output logic [2:0]      address_space_code
);
    import pstc_pkg::*;

    logic       start_q, start_d;
    logic [2:0] asc_q, asc_d;
    logic       sup;

    always_comb begin
        sup     = mode.supervisor | mode.in_exception;
        start_d = bus_req & mode.bus_allowed;
        asc_d   = asc_q;
        if (start_d) begin
            if (bus_cpu_space) begin
                asc_d = PSTC_ASC_CPU;
            end else if (sup) begin
                asc_d = bus_program ? PSTC_ASC_SUP_PROG : PSTC_ASC_SUP_DATA;
            end else begin
                asc_d = bus_program ? PSTC_ASC_USER_PROG : PSTC_ASC_USER_DATA;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            start_q <= 1'b0;
            asc_q   <= PSTC_ASC_RESET;
        end else begin
            start_q <= start_d;
            asc_q   <= asc_d;
        end
    end

    assign bus_start          = start_q;
    assign address_space_code = asc_q;

    property p_exc_super;
        @(posedge clock) disable iff (sys_rst)
        mode.in_exception && bus_req && !bus_cpu_space && mode.bus_allowed
            |=> bus_start && address_space_code[2];
    endproperty
    a_exc_super: assert property (p_exc_super) else $error("exception cycle not supervisor");

    property p_legal_code;
        @(posedge clock) disable iff (sys_rst)
        bus_start |-> address_space_code inside {3'h1, 3'h2, 3'h5, 3'h6, 3'h7};
    endproperty
    a_legal_code: assert property (p_legal_code) else $error("reserved space code");

    property p_user_code;
        @(posedge clock) disable iff (sys_rst)
        bus_req && mode.bus_allowed && !mode.supervisor && !mode.in_exception && !bus_cpu_space
            |=> address_space_code == ($past(bus_program) ? 3'h2 : 3'h1);
    endproperty
    a_user_code: assert property (p_user_code) else $error("user cycle mislabelled");
endmodule
`default_nettype wire

// ---- test/pstc_bus_model.sv ----
// Far-side bus model: counts the bus cycles that the core launches.
// Assumes bus_start is a one-cycle pulse synchronous to clock.
`timescale 1ns/1ns
`default_nettype none
module pstc_bus_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Bus cycle launch
    input  wire logic       bus_start,
    input  wire logic [2:0] address_space_code,
    // Observation
    output logic [7:0]      cycle_count,
    output logic [2:0]      last_code
);
    // Cleared only by the external reset, as the reset source owns recovery
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cycle_count <= 8'h00;
            last_code   <= 3'h0;
        end else if (bus_start) begin
            cycle_count <= cycle_count + 8'h01;
            last_code   <= address_space_code;
        end
    end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench of the state and privilege controller.
// Assumes pstc_core and the bus model; inputs driven 1 ns after clock edges.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import pstc_pkg::*;
    logic        clock, sys_rst, instr_valid, instr_privileged, instr_status_write, instr_stop;
    logic [15:0] instr_status_value, status_word, saved_status_word;
    logic        exc_interrupt_ack, exc_trace, exc_trap, exc_other;
    logic        bus_error, address_error, handler_begin, bus_req, bus_program, bus_cpu_space;
    logic        instr_accept, bus_start, stopped, supervisor, priv_violation;
    logic [2:0]  address_space_code, last_code;
    logic [7:0]  cycle_count, n;
    pstc_state_e proc_state;
    pstc_stack_e stack_select;
    int          failures, total_checks, cycles;

    pstc_core i_dut (.clock, .sys_rst, .instr_valid, .instr_privileged, .instr_status_write,
        .instr_stop, .instr_status_value, .instr_accept, .exc_interrupt_ack, .exc_trace,
        .exc_trap, .exc_other, .bus_error, .address_error, .handler_begin, .bus_req,
        .bus_program, .bus_cpu_space, .bus_start, .address_space_code, .proc_state, .stopped,
        .supervisor, .priv_violation, .status_word, .saved_status_word, .stack_select);
    pstc_bus_model i_bus (.clock, .sys_rst, .bus_start, .address_space_code, .cycle_count,
        .last_code);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // Safety net: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles >= 2000) begin
            failures++;
            test_done();
        end
    end

    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask

    task automatic idle;
        {instr_valid, instr_privileged, instr_status_write, instr_stop} = 4'h0;
        {exc_interrupt_ack, exc_trace, exc_trap, exc_other} = 4'h0;
        {bus_error, address_error, handler_begin, bus_req, bus_program, bus_cpu_space} = 6'h00;
    endtask

    // External reset source
    task automatic do_reset(input int k);
        sys_rst = 1'b1;
        step(k);
        sys_rst = 1'b0;
    endtask

    // Offer one instruction: {privileged, status write, stop}
    // Each driving task lets one edge pass first, so nothing lowered by the
    // previous task is raised again in the same time step
    task automatic issue(input logic [2:0] kind, input logic [15:0] v, input logic acc);
        step(1);
        instr_valid = 1'b1;
        {instr_privileged, instr_status_write, instr_stop} = kind;
        instr_status_value = v;
        #1;
        chk(instr_accept, acc);
        step(1);
        idle();
    endtask

    // Event pulse: {irq, trace, trap, other, bus error, address error, handler}
    task automatic ev(input logic [6:0] v);
        step(1);
        {exc_interrupt_ack, exc_trace, exc_trap, exc_other} = v[6:3];
        {bus_error, address_error, handler_begin} = v[2:0];
        step(1);
        idle();
    endtask

    task automatic bus(input logic prog, input logic cpu, input logic [2:0] code);
        step(1);
        {bus_req, bus_program, bus_cpu_space} = {1'b1, prog, cpu};
        step(1);
        idle();
        chk(bus_start, 1'b1);
        chk(address_space_code, code);
    endtask

    task automatic t_reset;
        chk(proc_state, PSTC_NORMAL);
        chk(status_word, 16'h2000);
        chk(stack_select, PSTC_SP_INTERRUPT);
        chk({supervisor, stopped, bus_start, priv_violation}, 4'h8);
    endtask

    task automatic t_master_irq;
        issue(3'h2, 16'h3000, 1'b1);
        chk(stack_select, PSTC_SP_MASTER);
        issue(3'h4, 16'h0000, 1'b1);
        bus(1'b0, 1'b0, PSTC_ASC_SUP_DATA);
        ev(7'h40);
        chk(proc_state, PSTC_EXCEPTION);
        chk(saved_status_word, 16'h3000);
        chk(status_word, 16'h2000);
        chk(stack_select, PSTC_SP_INTERRUPT);
        ev(7'h01);
        chk(proc_state, PSTC_NORMAL);
    endtask

    task automatic t_user;
        issue(3'h2, 16'h0000, 1'b1);
        chk({supervisor, stack_select}, {1'b0, PSTC_SP_USER});
        bus(1'b0, 1'b0, PSTC_ASC_USER_DATA);
        bus(1'b1, 1'b0, PSTC_ASC_USER_PROG);
        bus(1'b0, 1'b1, PSTC_ASC_CPU);
        issue(3'h4, 16'h0000, 1'b0);
        chk({priv_violation, proc_state}, {1'b1, PSTC_EXCEPTION});
        chk(supervisor, 1'b1);
        bus(1'b1, 1'b0, PSTC_ASC_SUP_PROG);
        ev(7'h01);
        issue(3'h2, 16'h0000, 1'b1);
        issue(3'h2, 16'h2000, 1'b0);
        chk(proc_state, PSTC_EXCEPTION);
        chk(status_word[PSTC_SW_S_BIT], 1'b1);
        chk(saved_status_word, 16'h0000);
        ev(7'h01);
    endtask

    task automatic t_stop;
        issue(3'h1, 16'h0000, 1'b1);
        chk({stopped, proc_state}, {1'b1, PSTC_NORMAL});
        n = cycle_count;
        step(1);
        bus_req = 1'b1;
        step(2);
        idle();
        chk(cycle_count, n);
        ev(7'h20);
        chk({stopped, proc_state}, {1'b0, PSTC_EXCEPTION});
        ev(7'h01);
    endtask

    task automatic t_halt(input logic [6:0] entry, input logic [6:0] fault);
        ev(entry);
        ev(fault);
        chk(proc_state, PSTC_HALTED);
        n = cycle_count;
        step(1);
        bus_req = 1'b1;
        step(2);
        idle();
        chk(cycle_count, n);
        issue(3'h2, 16'h0000, 1'b0);
        ev(7'h01);
        chk(proc_state, PSTC_HALTED);
        do_reset(2);
        chk(proc_state, PSTC_NORMAL);
    endtask

    initial begin
        idle();
        instr_status_value = 16'h0000;
        do_reset(20);
        t_reset();
        t_master_irq();
        t_user();
        t_stop();
        t_halt(7'h08, 7'h04);
        t_halt(7'h10, 7'h02);
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire
